/* File: core/mic_ctrl.sv */
// Magnetometer interrupt controller: data registers with shadowing,
// status flags, latch logic and the two interrupt pins.
// Assumes a register port on the core clock and a read_end pulse at the
// end of each host read sequence.
`default_nettype none

module mic_ctrl (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Measurement input
    input  wire logic             meas_valid,
    input  wire mic_pkg::mic_meas_t meas,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_rd,
    input  wire logic             read_end,
    output logic      [7:0]       reg_rdata,
    // Interrupt pins
    output logic                  gen_int_lvl,
    output logic                  gen_int_oe,
    output logic                  sample_ready_pin_lvl,
    output logic                  sample_ready_pin_oe
);

    mic_pkg::mic_meas_t data_r, data_nxt;
    mic_pkg::mic_meas_t shadow_r, shadow_nxt;
    logic       pend_r, pend_nxt;
    logic       rd_seen_r, rd_seen_nxt;
    logic [7:0] stat_r, stat_nxt;
    logic       ready_r, ready_nxt;
    logic       latch_r, latch_nxt;
    logic [7:0] src_en_r, src_en_nxt;
    logic [7:0] pin_set_r, pin_set_nxt;
    logic [7:0] low_lim_r, low_lim_nxt;
    logic [7:0] high_lim_r, high_lim_nxt;
    logic [7:0] rdata_nxt;
    logic       gen_o_nxt, rdy_o_nxt;

    // Register port decode.
    wire logic is_data;
    wire logic wr_status, wr_src, wr_pin, wr_low, wr_high;
    wire logic rd_status;
    assign is_data   = reg_addr >= mic_pkg::ADDR_X_LSB
                    && reg_addr <= mic_pkg::ADDR_RES_HIGH;
    assign wr_status = reg_wr && reg_addr == mic_pkg::ADDR_STATUS;
    assign wr_src    = reg_wr && reg_addr == mic_pkg::ADDR_SRC_EN;
    assign wr_pin    = reg_wr && reg_addr == mic_pkg::ADDR_PIN_SET;
    assign wr_low    = reg_wr && reg_addr == mic_pkg::ADDR_LOW_LIMIT;
    assign wr_high   = reg_wr && reg_addr == mic_pkg::ADDR_HIGH_LIMIT;
    assign rd_status = reg_rd && reg_addr == mic_pkg::ADDR_STATUS;

    // Updates are held off during a data read so the host never sees
    // one axis from an old set and another from a new one.
    wire logic busy;
    wire logic commit_new, commit_shadow, commit;
    assign busy          = rd_seen_r || (reg_rd && is_data);
    assign commit_new    = meas_valid && !busy && !read_end;
    assign commit_shadow = read_end && (pend_r || meas_valid);
    assign commit        = commit_new || commit_shadow;

    // Incoming set with overflow saturation applied.
    mic_pkg::mic_meas_t sat_in, src_set;
    always_comb begin
        sat_in = meas;
        if (meas.ovf[0]) begin
            sat_in.x = mic_pkg::SAT_XY;
        end
        if (meas.ovf[1]) begin
            sat_in.y = mic_pkg::SAT_XY;
        end
        if (meas.ovf[2]) begin
            sat_in.z = mic_pkg::SAT_Z;
        end
    end
    assign src_set = meas_valid ? sat_in : shadow_r;

    // Per-axis comparisons on the set about to be stored.
    wire logic [2:0] below;
    wire logic [2:0] above;

    mic_axis_cmp #(
        .W        (13),
        .SKIP_SAT (1'b1),
        .SAT      (mic_pkg::SAT_XY)
    ) u_cmp_x (
        .value      (src_set.x),
        .low_limit  (low_lim_r),
        .high_limit (high_lim_r),
        .below      (below[0]),
        .above      (above[0])
    );

    mic_axis_cmp #(
        .W        (13),
        .SKIP_SAT (1'b1),
        .SAT      (mic_pkg::SAT_XY)
    ) u_cmp_y (
        .value      (src_set.y),
        .low_limit  (low_lim_r),
        .high_limit (high_lim_r),
        .below      (below[1]),
        .above      (above[1])
    );

    // Only X and Y have the saturation exception.
    mic_axis_cmp #(
        .W        (15),
        .SKIP_SAT (1'b0),
        .SAT      (mic_pkg::SAT_Z)
    ) u_cmp_z (
        .value      (src_set.z),
        .low_limit  (low_lim_r),
        .high_limit (high_lim_r),
        .below      (below[2]),
        .above      (above[2])
    );

    // Source enables; threshold ones are active low.
    wire logic [2:0] low_en, high_en;
    wire logic       ovf_en, overrun_en;
    assign low_en     = ~src_en_r[mic_pkg::EN_LOW_X_N +: 3];
    assign high_en    = ~src_en_r[mic_pkg::EN_HIGH_X_N +: 3];
    assign ovf_en     = src_en_r[mic_pkg::EN_OVF];
    assign overrun_en = src_en_r[mic_pkg::EN_OVERRUN];

    // New conditions; threshold and overrun ones gated by the enables, overflow ungated.
    wire logic [2:0] low_hit, high_hit;
    wire logic       ovf_hit, overrun_hit;
    assign low_hit     = below & low_en;
    assign high_hit    = above & high_en;
    assign ovf_hit     = meas_valid ? |meas.ovf : |shadow_r.ovf;
    assign overrun_hit = overrun_en && ready_r;

    // Held threshold flags keep only their still-enabled part, so a disabled
    // threshold source drops out at the next stored measurement; a held overflow flag stays.
    wire logic [6:0] cur_flags, held_flags, new_flags;
    assign cur_flags  = stat_r[6:0];
    assign held_flags = cur_flags
                      & {ovf_en | cur_flags[mic_pkg::STAT_OVF],
                         high_en, low_en};
    assign new_flags  = {ovf_hit, high_hit, low_hit};

    always_comb begin
        stat_nxt = stat_r;
        // Latched flags are cleared by a status read.
        if (rd_status && latch_r) begin
            stat_nxt[6:0] = 7'h00;
        end
        if (rd_status) begin
            stat_nxt[mic_pkg::STAT_OVERRUN] = 1'b0;
        end
        // A stored set wins over a clear in the same cycle.
        if (commit) begin
            if (latch_r) begin
                stat_nxt[6:0] = new_flags
                              | (rd_status ? 7'h00 : held_flags);
            end else begin
                stat_nxt[6:0] = new_flags;
            end
            if (overrun_hit) begin
                stat_nxt[mic_pkg::STAT_OVERRUN] = 1'b1;
            end
        end
    end

    // Sample ready: always non-latched, set on store, cleared once a read
    // sequence that touched the data registers ends.
    always_comb begin
        ready_nxt = ready_r;
        if (read_end && rd_seen_r) begin
            ready_nxt = 1'b0;
        end
        if (commit) begin
            ready_nxt = 1'b1;
        end
    end

    // Data registers and shadow.
    always_comb begin
        data_nxt   = data_r;
        shadow_nxt = shadow_r;
        pend_nxt   = pend_r;
        if (commit) begin
            data_nxt = src_set;
            pend_nxt = 1'b0;
        end
        if (meas_valid && busy && !read_end) begin
            shadow_nxt = sat_in;
            pend_nxt   = 1'b1;
        end
    end

    assign rd_seen_nxt = read_end ? 1'b0 : (rd_seen_r || (reg_rd && is_data));

    // Configuration writes; 0x4a accepts only the latch bit.
    assign latch_nxt    = wr_status ? reg_wdata[mic_pkg::STAT_LATCH]
                                    : latch_r;
    assign src_en_nxt   = wr_src  ? reg_wdata : src_en_r;
    assign pin_set_nxt  = wr_pin  ? (reg_wdata & 8'hc5) : pin_set_r;
    assign low_lim_nxt  = wr_low  ? reg_wdata : low_lim_r;
    assign high_lim_nxt = wr_high ? reg_wdata : high_lim_r;

    // Read data mux.
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            mic_pkg::ADDR_X_LSB:      rdata_nxt = {data_r.x[4:0], 3'h0};
            mic_pkg::ADDR_X_MSB:      rdata_nxt = data_r.x[12:5];
            mic_pkg::ADDR_Y_LSB:      rdata_nxt = {data_r.y[4:0], 3'h0};
            mic_pkg::ADDR_Y_MSB:      rdata_nxt = data_r.y[12:5];
            mic_pkg::ADDR_Z_LSB:      rdata_nxt = {data_r.z[6:0], 1'b0};
            mic_pkg::ADDR_Z_MSB:      rdata_nxt = data_r.z[14:7];
            mic_pkg::ADDR_RES_LOW:    rdata_nxt = {data_r.res[5:0], 1'b0,
                                                   ready_r};
            mic_pkg::ADDR_RES_HIGH:   rdata_nxt = data_r.res[13:6];
            mic_pkg::ADDR_STATUS:     rdata_nxt = stat_r;
            mic_pkg::ADDR_SRC_EN:     rdata_nxt = src_en_r;
            mic_pkg::ADDR_PIN_SET:    rdata_nxt = pin_set_r
                                    | {6'h00, latch_r, 1'b0};
            mic_pkg::ADDR_LOW_LIMIT:  rdata_nxt = low_lim_r;
            mic_pkg::ADDR_HIGH_LIMIT: rdata_nxt = high_lim_r;
            default:                  rdata_nxt = 8'h00;
        endcase
    end

    // Pin levels follow the stored flags; the ready pin has its own
    // path so it never appears on the general pin.
    // The overflow term takes the next enable, so the pin answers an
    // enable write at the same edge as a polarity or pin enable write.
    wire logic gen_level;
    wire logic gen_oe_nxt, rdy_oe_nxt;
    assign gen_level = |stat_nxt[mic_pkg::STAT_LOW_X +: 3]
                    || |stat_nxt[mic_pkg::STAT_HIGH_X +: 3]
                    || (stat_nxt[mic_pkg::STAT_OVF]
                        && src_en_nxt[mic_pkg::EN_OVF]);
    assign gen_o_nxt = gen_level
                     ^ ~pin_set_nxt[mic_pkg::PIN_GEN_POL];
    assign rdy_o_nxt = ready_nxt
                     ^ ~pin_set_nxt[mic_pkg::PIN_READY_POL];
    assign gen_oe_nxt = pin_set_nxt[mic_pkg::PIN_GEN_EN];
    assign rdy_oe_nxt = pin_set_nxt[mic_pkg::PIN_READY_EN];

    // Measurement path: data, shadow and read tracking.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_r    <= '0;
            shadow_r  <= '0;
            pend_r    <= 1'b0;
            rd_seen_r <= 1'b0;
        end else begin
            data_r    <= data_nxt;
            shadow_r  <= shadow_nxt;
            pend_r    <= pend_nxt;
            rd_seen_r <= rd_seen_nxt;
        end
    end

    // Status flags and the sample ready flag.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_r  <= 8'h00;
            ready_r <= 1'b0;
        end else begin
            stat_r  <= stat_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Configuration; after reset both pins float.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_r   <= mic_pkg::LATCH_RST;
            src_en_r  <= mic_pkg::SRC_EN_RST;
            pin_set_r <= mic_pkg::PIN_SET_RST;
        end else begin
            latch_r   <= latch_nxt;
            src_en_r  <= src_en_nxt;
            pin_set_r <= pin_set_nxt;
        end
    end

    // Threshold limits.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            low_lim_r  <= mic_pkg::LIMIT_RST;
            high_lim_r <= mic_pkg::LIMIT_RST;
        end else begin
            low_lim_r  <= low_lim_nxt;
            high_lim_r <= high_lim_nxt;
        end
    end

    // Read data is registered, so it lags the address by one cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Pin flops take next values, so a pin moves at the same edge as the
    // flag or setting behind it; the enables make the pins push-pull or
    // floating.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gen_int_lvl          <= 1'b0;
            gen_int_oe           <= 1'b0;
            sample_ready_pin_lvl <= 1'b0;
            sample_ready_pin_oe  <= 1'b0;
        end else begin
            gen_int_lvl          <= gen_o_nxt;
            gen_int_oe           <= gen_oe_nxt;
            sample_ready_pin_lvl <= rdy_o_nxt;
            sample_ready_pin_oe  <= rdy_oe_nxt;
        end
    end

endmodule : mic_ctrl

`default_nettype wire

/* File: core/mic_pkg.sv */
// Package of the magnetometer interrupt controller: register map,
// field positions, reset values and the measurement carrier type.
// Assumes a single 25 MHz core clock and a synchronous active-high reset.
`default_nettype none

package mic_pkg;

    // Register offsets.
    localparam logic [7:0] ADDR_X_LSB      = 8'h42;
    localparam logic [7:0] ADDR_X_MSB      = 8'h43;
    localparam logic [7:0] ADDR_Y_LSB      = 8'h44;
    localparam logic [7:0] ADDR_Y_MSB      = 8'h45;
    localparam logic [7:0] ADDR_Z_LSB      = 8'h46;
    localparam logic [7:0] ADDR_Z_MSB      = 8'h47;
    localparam logic [7:0] ADDR_RES_LOW    = 8'h48;
    localparam logic [7:0] ADDR_RES_HIGH   = 8'h49;
    localparam logic [7:0] ADDR_STATUS     = 8'h4a;
    localparam logic [7:0] ADDR_SRC_EN     = 8'h4d;
    localparam logic [7:0] ADDR_PIN_SET    = 8'h4e;
    localparam logic [7:0] ADDR_LOW_LIMIT  = 8'h4f;
    localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h50;

    // Field positions in the status register.
    localparam int STAT_LOW_X   = 0;
    localparam int STAT_HIGH_X  = 3;
    localparam int STAT_OVF     = 6;
    localparam int STAT_OVERRUN = 7;
    localparam int STAT_LATCH   = 1;

    // Field positions in the source enable register.
    localparam int EN_LOW_X_N   = 0;
    localparam int EN_HIGH_X_N  = 3;
    localparam int EN_OVF       = 6;
    localparam int EN_OVERRUN   = 7;

    // Field positions in the pin settings register.
    localparam int PIN_GEN_POL   = 0;
    localparam int PIN_READY_POL = 2;
    localparam int PIN_GEN_EN    = 6;
    localparam int PIN_READY_EN  = 7;

    // Position of the sample ready flag in the resistance low byte.
    localparam int RES_READY    = 0;

    // Values after reset.
    localparam logic [7:0] SRC_EN_RST  = 8'h3f;
    localparam logic [7:0] PIN_SET_RST = 8'h05;
    localparam logic [7:0] LIMIT_RST   = 8'h00;
    localparam logic       LATCH_RST   = 1'b1;

    // Saturation codes written on overflow.
    localparam logic signed [12:0] SAT_XY = -13'sd4096;
    localparam logic signed [14:0] SAT_Z  = -15'sd16384;

    // Threshold scale is a left shift by four, i.e. times sixteen.
    localparam int LIMIT_SHIFT = 4;

    typedef struct packed {
        logic signed [12:0] x;
        logic signed [12:0] y;
        logic signed [14:0] z;
        logic        [13:0] res;
        logic        [2:0]  ovf;
    } mic_meas_t;

endpackage : mic_pkg

`default_nettype wire

/* File: core/mic_axis_cmp.sv */
// Per-axis threshold comparator of the magnetometer interrupt controller.
// Assumes its inputs are stable registered values; purely combinational.
`default_nettype none

module mic_axis_cmp #(
    parameter int                W       = 13,
    parameter logic              SKIP_SAT = 1'b1,
    parameter logic signed [W-1:0] SAT   = '0
) (
    // Axis value and limits
    input  wire logic signed [W-1:0] value,
    input  wire logic        [7:0]   low_limit,
    input  wire logic        [7:0]   high_limit,
    // Results
    output logic                     below,
    output logic                     above
);

    wire logic signed [15:0] value_ext;
    wire logic signed [15:0] low_ext;
    wire logic signed [15:0] high_ext;
    wire logic               is_sat;

    // Signed compare on two's complement values.
    assign value_ext = 16'(value);
    assign low_ext   = 16'(signed'({low_limit, 4'h0}));
    assign high_ext  = 16'(signed'({high_limit, 4'h0}));
    assign is_sat    = SKIP_SAT && (value == SAT);
    assign below     = (value_ext < low_ext) && !is_sat;
    assign above     = value_ext > high_ext;

endmodule : mic_axis_cmp

`default_nettype wire

/* File: verification/mic_ctrl_monitor.sv */
// Checker of the interrupt controller ports.
// Assumes it is bound into mic_ctrl and sees only that module's ports.
`default_nettype none

module mic_ctrl_monitor (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               rst,
    // Stimulus side
    input wire logic               meas_valid,
    input wire mic_pkg::mic_meas_t meas,
    input wire logic [7:0]         reg_addr,
    input wire logic               reg_wr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_rd,
    input wire logic               read_end,
    // Design outputs
    input wire logic [7:0]         reg_rdata,
    input wire logic               gen_int_lvl,
    input wire logic               gen_int_oe,
    input wire logic               sample_ready_pin_lvl,
    input wire logic               sample_ready_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic latch_r;
    logic pol_r;
    wire  pin_wr   = reg_wr && reg_addr == mic_pkg::ADDR_PIN_SET;
    wire  st_rd    = reg_rd && reg_addr == mic_pkg::ADDR_STATUS;
    wire  no_store = !meas_valid && !read_end;
    wire  quiet    = no_store && !reg_wr;
    // Mirror of latch mode and general polarity, as last written.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_r <= 1'b1;
            pol_r   <= 1'b1;
        end else if (reg_wr && reg_addr == mic_pkg::ADDR_STATUS) begin
            latch_r <= reg_wdata[1];
        end else if (pin_wr) begin
            pol_r <= reg_wdata[0];
        end
    end
    sequence src_wr_then_rd;
        reg_wr && reg_addr == mic_pkg::ADDR_SRC_EN
        ##1 !reg_wr && reg_addr == mic_pkg::ADDR_SRC_EN;
    endsequence
    chk_reset_pins_off: assert property ($fell(rst) |->
        !gen_int_oe && !sample_ready_pin_oe)
        else $error("pin driven right after reset");
    chk_gen_oe_write: assert property (pin_wr |=>
        gen_int_oe == $past(reg_wdata[6]))
        else $error("general pin enable ignores write");
    chk_ready_oe_write: assert property (pin_wr |=>
        sample_ready_pin_oe == $past(reg_wdata[7]))
        else $error("ready pin enable ignores write");
    chk_oe_hold: assert property (!pin_wr |=>
        $stable(gen_int_oe) && $stable(sample_ready_pin_oe))
        else $error("pin enable moved without write");
    chk_latch_clear: assert property (st_rd && latch_r && quiet
        && gen_int_oe |=> gen_int_lvl == !pol_r)
        else $error("latched pin not cleared by status read");
    chk_gen_hold: assert property (quiet && !st_rd |=>
        $stable(gen_int_lvl))
        else $error("general pin moved without cause");
    chk_ready_hold: assert property (no_store && !pin_wr |=>
        $stable(sample_ready_pin_lvl))
        else $error("ready pin moved without cause");
    chk_src_en_readback: assert property (src_wr_then_rd |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("source enable readback wrong");
    cov_latched_read: cover property (st_rd && latch_r);
    cov_meas_gen_on: cover property (meas_valid && gen_int_oe);
    cov_read_end_ready: cover property (read_end && sample_ready_pin_oe);
endmodule : mic_ctrl_monitor

bind mic_ctrl mic_ctrl_monitor mic_ctrl_monitor_inst (
    .core_clk(core_clk), .rst(rst), .meas_valid(meas_valid),
    .meas(meas), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .read_end(read_end),
    .reg_rdata(reg_rdata), .gen_int_lvl(gen_int_lvl),
    .gen_int_oe(gen_int_oe),
    .sample_ready_pin_lvl(sample_ready_pin_lvl),
    .sample_ready_pin_oe(sample_ready_pin_oe)
);

`default_nettype wire

/* File: verification/mic_host_pins.sv */
// Host side model of the two interrupt pins as the host sees them.
// Assumes output and enable pairs from the controller on core_clk.
`default_nettype none

module mic_host_pins (
    // Clock
    input  wire logic core_clk,
    // Controller pin pairs
    input  wire logic gen_drv,
    input  wire logic gen_oe,
    input  wire logic rdy_drv,
    input  wire logic rdy_oe,
    // Levels seen by the host
    output logic      gen_lvl,
    output logic      rdy_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating pin shows the inverse of the level last driven on it,
    // so a reading from an undriven pin cannot match by chance.
    logic gen_last;
    logic rdy_last;
    always_ff @(posedge core_clk) begin
        if (gen_oe) begin
            gen_last <= gen_drv;
        end
        if (rdy_oe) begin
            rdy_last <= rdy_drv;
        end
    end
    assign gen_lvl = gen_oe ? gen_drv : ~gen_last;
    assign rdy_lvl = rdy_oe ? rdy_drv : ~rdy_last;
endmodule : mic_host_pins

`default_nettype wire

/* File: verification/mic_ctrl_test.sv */
// Self-checking bench of the magnetometer interrupt controller.
// Assumes mic_ctrl with its bound checker and the host pin model.
`default_nettype none

module mic_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [12:0] x;
        logic [12:0] y;
        logic [14:0] z;
        logic [2:0]  ovf;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [7:0]  st;
        logic        gen;
    } mic_row_t;
    logic core_clk, rst, meas_valid, reg_wr, reg_rd, read_end;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic gen_int_lvl, gen_int_oe, sample_ready_pin_lvl, sample_ready_pin_oe;
    logic gen_lvl, rdy_lvl;
    mic_pkg::mic_meas_t meas;
    int errors, n_checks;
    mic_row_t rows [6] = '{
        '{13'h0000, 13'h0000, 15'h0000, 3'h0, 8'hff, 8'h01, 8'h00, 1'b0},
        '{13'h1fef, 13'h0011, 15'h0000, 3'h0, 8'hff, 8'h01, 8'h11, 1'b1},
        '{13'h1ff0, 13'h0010, 15'h7fec, 3'h0, 8'hff, 8'h01, 8'h04, 1'b1},
        '{13'h0000, 13'h0000, 15'h0000, 3'h1, 8'hff, 8'h01, 8'h40, 1'b0},
        '{13'h0000, 13'h0000, 15'h0000, 3'h4, 8'hff, 8'h01, 8'h44, 1'b1},
        '{13'h0064, 13'h0064, 15'h0064, 3'h0, 8'h7f, 8'h80, 8'h3f, 1'b1}
    };
    mic_ctrl mic_ctrl_inst (
        .core_clk(core_clk), .rst(rst), .meas_valid(meas_valid),
        .meas(meas), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .read_end(read_end),
        .reg_rdata(reg_rdata), .gen_int_lvl(gen_int_lvl),
        .gen_int_oe(gen_int_oe),
        .sample_ready_pin_lvl(sample_ready_pin_lvl),
        .sample_ready_pin_oe(sample_ready_pin_oe)
    );
    mic_host_pins mic_host_pins_inst (
        .core_clk(core_clk), .gen_drv(gen_int_lvl), .gen_oe(gen_int_oe),
        .rdy_drv(sample_ready_pin_lvl), .rdy_oe(sample_ready_pin_oe),
        .gen_lvl(gen_lvl), .rdy_lvl(rdy_lvl)
    );
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic cmp8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : cmp8
    task automatic cmp1(input string n, input logic e, input logic g);
        cmp8(n, {7'h00, e}, {7'h00, g});
    endtask : cmp1
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        step();
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        step();
        reg_addr = a;
        reg_rd = 1'b1;
        step();
        reg_rd = 1'b0;
        cmp8("reg_rdata", e, reg_rdata);
    endtask : rdc
    task automatic ms(input logic [12:0] x, input logic [12:0] y,
                      input logic [14:0] z, input logic [2:0] ovf);
        step();
        meas = '{x, y, z, 14'h0000, ovf};
        meas_valid = 1'b1;
        step();
        meas_valid = 1'b0;
    endtask : ms
    task automatic fin();
        step();
        read_end = 1'b1;
        step();
        read_end = 1'b0;
    endtask : fin
    task automatic rst5();
        rst = 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        rst = 1'b0;
    endtask : rst5
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    // The full run is about 150 cycles; this leaves ample margin.
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    initial begin
        {meas_valid, reg_wr, reg_rd, read_end} = 4'h0;
        meas = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        errors = 0;
        n_checks = 0;
        rst5();
        wr(8'h4a, 8'h00);
        wr(8'h4d, 8'h00);
        rdc(8'h4d, 8'h00);
        wr(8'h4e, 8'hc5);
        rdc(8'h4e, 8'hc5);
        foreach (rows[i]) begin
            wr(8'h4f, rows[i].lo);
            wr(8'h50, rows[i].hi);
            ms(rows[i].x, rows[i].y, rows[i].z, rows[i].ovf);
            cmp1("gen_lvl", rows[i].gen, gen_lvl);
            cmp1("rdy_lvl", 1'b1, rdy_lvl);
            rdc(8'h4a, rows[i].st);
            rdc(8'h48, 8'h01);
            fin();
            cmp1("rdy_lvl", 1'b0, rdy_lvl);
        end
        rst5();
        cmp1("gen_int_oe", 1'b0, gen_int_oe);
        cmp1("sample_ready_pin_oe", 1'b0, sample_ready_pin_oe);
        rdc(8'h4d, 8'h3f);
        rdc(8'h4e, 8'h07);
        rdc(8'h4a, 8'h00);
        rdc(8'h60, 8'h00);
        wr(8'h4d, 8'h3e);
        wr(8'h4e, 8'h41);
        wr(8'h4f, 8'h01);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h0);
        cmp1("gen_lvl", 1'b1, gen_lvl);
        ms(13'h0064, 13'h0000, 15'h0000, 3'h0);
        cmp1("gen_lvl", 1'b1, gen_lvl);
        cmp1("sample_ready_pin_oe", 1'b0, sample_ready_pin_oe);
        rdc(8'h4a, 8'h01);
        cmp1("gen_lvl", 1'b0, gen_lvl);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h0);
        wr(8'h4d, 8'h3f);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h0);
        cmp1("gen_lvl", 1'b0, gen_lvl);
        rdc(8'h4a, 8'h00);
        wr(8'h4d, 8'h7f);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h2);
        cmp1("gen_lvl", 1'b1, gen_lvl);
        rdc(8'h4a, 8'h40);
        rdc(8'h45, 8'h80);
        fin();
        wr(8'h4e, 8'hc0);
        cmp1("gen_lvl", 1'b1, gen_lvl);
        cmp1("rdy_lvl", 1'b1, rdy_lvl);
        wr(8'h4e, 8'hc5);
        rdc(8'h42, 8'h00);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h0);
        cmp1("rdy_lvl", 1'b0, rdy_lvl);
        fin();
        cmp1("rdy_lvl", 1'b1, rdy_lvl);
        rdc(8'h48, 8'h01);
        fin();
        cmp1("rdy_lvl", 1'b0, rdy_lvl);
        wr(8'h4d, 8'hff);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h0);
        ms(13'h0000, 13'h0000, 15'h0064, 3'h0);
        rdc(8'h4a, 8'h80);
        rdc(8'h4a, 8'h00);
        end_of_test();
    end
endmodule : mic_ctrl_test

`default_nettype wire
